// *** rtl/dmba_pkg.sv ***
// Package: constants and carrier types for the data memory bus priority arbiter
// Function
// - Arbitrate data memory among CPU, DMA, USB, debugger
// - Grant only highest requester, stall the rest
// - Default: CPU highest slot, debugger lowest slot
// - Default: USB slot two, DMA slot three
// - Control bits raise USB or DMA above CPU
// - Raised masters keep USB above DMA order
// - Lowered masters keep order, debugger always last
// - Four control values give four fixed orderings
// - Priority changes apply to later arbitration anytime
package dmba_pkg;
    // ==========================================================
    // Master indices and widths
    localparam int DMBA_NUM_MASTERS = 4;
    localparam int DMBA_IDX_CPU = 0;
    localparam int DMBA_IDX_DMA = 1;
    localparam int DMBA_IDX_USB = 2;
    localparam int DMBA_IDX_DBG = 3;
    localparam int DMBA_CTRL_W = 16;

    // ==========================================================
    // Priority control field positions and legal values
    localparam int DMBA_BIT_USB_RAISE = 3;
    localparam int DMBA_BIT_DMA_RAISE = 5;
    localparam logic [15:0] DMBA_CTRL_RESET = 16'h0000;
    localparam logic [15:0] DMBA_CTRL_USB_UP = 16'h0008;
    localparam logic [15:0] DMBA_CTRL_DMA_UP = 16'h0020;
    localparam logic [15:0] DMBA_CTRL_BOTH_UP = 16'h0028;

    // One request or grant bit per master
    typedef struct packed {
        logic dbg;
        logic usb;
        logic dma;
        logic cpu;
    } dmba_vec_t;

    // Arbiter state: idle or a master owning the bus
    typedef enum logic [1:0] {
        DMBA_IDLE = 2'b01,
        DMBA_BUSY = 2'b10
    } dmba_state_t;
endpackage

// *** rtl/dmba_pick.sv ***
// Combinational fixed-order pick of the winning requester
module dmba_pick
    import dmba_pkg::*;
(
    input wire logic [15:0] i_ctrl,
    input wire dmba_vec_t i_req,
    output dmba_vec_t o_win
);
    // ==========================================================
    // Priority resolution
    logic usb_up;
    logic dma_up;
    always_comb begin
        usb_up = i_ctrl[DMBA_BIT_USB_RAISE];
        dma_up = i_ctrl[DMBA_BIT_DMA_RAISE];
        o_win = '0;
        // Raised masters first, USB ahead of DMA
        if (usb_up && i_req.usb) begin
            o_win.usb = 1'b1;
        end else if (dma_up && i_req.dma) begin
            o_win.dma = 1'b1;
        end else if (i_req.cpu) begin
            o_win.cpu = 1'b1;
        end else if (!usb_up && i_req.usb) begin
            o_win.usb = 1'b1;
        end else if (!dma_up && i_req.dma) begin
            o_win.dma = 1'b1;
        end else if (i_req.dbg) begin
            o_win.dbg = 1'b1;
        end
    end
endmodule

// *** rtl/dmba_arbiter.sv ***
// Top: data memory bus priority arbiter with request latching
module dmba_arbiter
    import dmba_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [15:0] i_bus_master_priority_control,
    input wire dmba_vec_t i_req,
    input wire logic i_done,
    output dmba_vec_t o_grant,
    output dmba_vec_t o_pending,
    output logic o_busy
);
    // ==========================================================
    // Reset release: two flops so reset leaves on a clock edge
    logic rst_s1;
    logic rst_b;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_s1 <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_b <= rst_s1;
        end
    end

    // ==========================================================
    // Priority control capture
    logic [15:0] ctrl; // Registered ordering in force
    logic [15:0] next_ctrl;
    always_comb begin
        // New setting taken at any edge with clock enable high, used by the next pick
        next_ctrl = i_bus_master_priority_control;
    end
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= DMBA_CTRL_RESET;
        end else if (i_ce) begin
            ctrl <= next_ctrl;
        end
    end

    // ==========================================================
    // Pending requests and winner
    dmba_vec_t pend; // Requests held while stalled
    dmba_vec_t want; // Live plus held requests
    dmba_vec_t win;
    always_comb begin
        want = pend | i_req;
    end

    dmba_pick u_pick (
        .i_ctrl(ctrl),
        .i_req(want),
        .o_win(win)
    );

    // ==========================================================
    // Grant state machine
    dmba_state_t state;
    dmba_state_t next_state;
    dmba_vec_t grant;
    dmba_vec_t next_grant;
    dmba_vec_t next_pend;
    logic can_pick;
    logic busy; // Owner present, kept as its own flop for the output pin
    logic next_busy;
    always_comb begin
        next_state = state;
        next_grant = grant;
        // Keep every request not yet served; a grant retires only its own
        next_pend = want;
        can_pick = 1'b0;
        case (state)
            DMBA_IDLE: begin
                can_pick = 1'b1;
            end
            DMBA_BUSY: begin
                next_pend = want & ~grant;
                // Others stay suspended until this access ends
                if (i_done) begin
                    can_pick = 1'b1;
                end
            end
            default: begin
                next_state = DMBA_IDLE;
                next_grant = '0;
            end
        endcase
        if (can_pick) begin
            next_pend = want & ~win;
            next_grant = win;
            next_state = (win != '0) ? DMBA_BUSY : DMBA_IDLE;
            // An owner still asking in its last cycle counts as a new
            // request: it waits if a higher master takes the bus instead
        end
        // Busy mirrors the state so the output pin needs no decode
        next_busy = (next_state == DMBA_BUSY);
    end
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= DMBA_IDLE;
            grant <= '0;
            pend <= '0;
            busy <= 1'b0;
        end else if (i_ce) begin
            state <= next_state;
            grant <= next_grant;
            pend <= next_pend;
            busy <= next_busy;
        end
    end

    // ==========================================================
    // Output registers
    // Every output is a plain copy of a flop, so no decode glitches
    always_comb begin
        o_grant = grant;
        o_pending = pend;
        o_busy = busy;
    end

    // ==========================================================
    // Checks
    logic hi_cpu;
    always_comb begin
        hi_cpu = !ctrl[DMBA_BIT_USB_RAISE] && !ctrl[DMBA_BIT_DMA_RAISE];
    end

    // Bus free: a winner may be chosen at this edge
    sequence s_pick;
        i_ce && state == DMBA_IDLE;
    endsequence

    // Owner still mid access: nobody else may take the bus
    sequence s_hold;
        i_ce && state == DMBA_BUSY && !i_done;
    endsequence

    // Owner finishes this cycle: the next winner is chosen now
    sequence s_handover;
        i_ce && state == DMBA_BUSY && i_done;
    endsequence

    a_grant_onehot: assert property (@(posedge i_clk) disable iff (!rst_b)
        $onehot0(grant)) else $error("grant not one-hot");
    a_cpu_first: assert property (@(posedge i_clk) disable iff (!rst_b)
        s_pick and hi_cpu && want.cpu |=> grant.cpu)
        else $error("cpu lost default priority");
    a_usb_over_dma: assert property (@(posedge i_clk) disable iff (!rst_b)
        s_pick and !want.cpu && want.usb
        && !(ctrl[DMBA_BIT_DMA_RAISE] && !ctrl[DMBA_BIT_USB_RAISE]) |=> !grant.dma)
        else $error("dma beat usb");
    a_raised_usb: assert property (@(posedge i_clk) disable iff (!rst_b)
        s_pick and ctrl[DMBA_BIT_USB_RAISE] && want.usb |=> grant.usb)
        else $error("raised usb not granted");
    a_raised_dma: assert property (@(posedge i_clk) disable iff (!rst_b)
        s_pick and ctrl[DMBA_BIT_DMA_RAISE] && want.dma
        && !(ctrl[DMBA_BIT_USB_RAISE] && want.usb) |=> grant.dma)
        else $error("raised dma not granted");
    a_dbg_last: assert property (@(posedge i_clk) disable iff (!rst_b)
        s_pick and (want.cpu || want.usb || want.dma) |=> !grant.dbg)
        else $error("debugger beat another master");
    a_hold_busy: assert property (@(posedge i_clk) disable iff (!rst_b)
        i_ce && state == DMBA_BUSY && !i_done |=> $stable(grant))
        else $error("grant changed mid access");
    a_keep_req: assert property (@(posedge i_clk) disable iff (!rst_b)
        i_ce && i_req.dbg && !win.dbg && !grant.dbg |=> pend.dbg)
        else $error("stalled request lost");
    a_ctrl_apply: assert property (@(posedge i_clk) disable iff (!rst_b)
        i_ce |=> ctrl == $past(i_bus_master_priority_control))
        else $error("priority setting not applied");

    // ==========================================================
    // Structural checks on the registered grant state
    // Busy flag, state and grant must always tell the same story
    a_busy_agrees: assert property (@(posedge i_clk) disable iff (!rst_b)
        busy == (state == DMBA_BUSY) && (busy == (grant != '0)))
        else $error("busy flag disagrees with grant");
    // A master is never owner and waiting at once
    a_pend_apart: assert property (@(posedge i_clk) disable iff (!rst_b)
        (pend & grant) == '0)
        else $error("owner also shown pending");
    // Clock enable low freezes grant, state, priority and held requests
    a_ce_freeze: assert property (@(posedge i_clk) disable iff (!rst_b)
        !i_ce |=> $stable(grant) && $stable(pend) && $stable(state) && $stable(ctrl))
        else $error("state moved while clock enable low");
    // Mid access the owner keeps the bus unchanged
    a_hold_owner: assert property (@(posedge i_clk) disable iff (!rst_b)
        s_hold |=> busy && grant == $past(grant))
        else $error("owner lost bus mid access");

    // ==========================================================
    // Stalled requests of every master survive until they win
    // The owner itself is left out: its live request is not a stall
    a_keep_cpu: assert property (@(posedge i_clk) disable iff (!rst_b)
        i_ce && i_req.cpu && !win.cpu && !grant.cpu |=> pend.cpu)
        else $error("stalled cpu request lost");
    a_keep_dma: assert property (@(posedge i_clk) disable iff (!rst_b)
        i_ce && i_req.dma && !win.dma && !grant.dma |=> pend.dma)
        else $error("stalled dma request lost");
    a_keep_usb: assert property (@(posedge i_clk) disable iff (!rst_b)
        i_ce && i_req.usb && !win.usb && !grant.usb |=> pend.usb)
        else $error("stalled usb request lost");

    // ==========================================================
    // Ordering checks, both from idle and at a handover
    // Nobody asking leaves the bus idle
    a_idle_none: assert property (@(posedge i_clk) disable iff (!rst_b)
        s_pick and want == '0 |=> state == DMBA_IDLE && grant == '0)
        else $error("grant without request");
    // Lowered usb still ranks above lowered dma
    a_lowered_usb: assert property (@(posedge i_clk) disable iff (!rst_b)
        s_pick and !ctrl[DMBA_BIT_USB_RAISE] && !want.cpu && want.usb
        && !(ctrl[DMBA_BIT_DMA_RAISE] && want.dma) |=> grant.usb)
        else $error("lowered usb order broken");
    // At the end of an access the next winner follows the same order
    a_handover_cpu: assert property (@(posedge i_clk) disable iff (!rst_b)
        s_handover and hi_cpu && want.cpu |=> grant.cpu)
        else $error("cpu lost priority at handover");
    // Both raised: usb stays ahead of dma
    a_both_raised: assert property (@(posedge i_clk) disable iff (!rst_b)
        s_handover and ctrl[DMBA_BIT_USB_RAISE] && ctrl[DMBA_BIT_DMA_RAISE]
        && want.usb |=> grant.usb)
        else $error("usb not ahead of dma when both raised");
    // With nobody waiting the bus falls idle after the access
    a_release_idle: assert property (@(posedge i_clk) disable iff (!rst_b)
        s_handover and want == '0 |=> !busy && grant == '0)
        else $error("grant kept after access ended");
endmodule

// *** verification/dmba_masters.sv ***
// Partner model: four bus masters and the owner's done pulse
module dmba_masters
    import dmba_pkg::*;
(
    input wire logic i_clk,
    input wire logic [15:0] i_rnd,
    input wire dmba_vec_t i_grant,
    output dmba_vec_t o_req,
    output logic o_done
);
    timeunit 1ns;
    timeprecision 100ps;
    // ========
    // Masters
    initial begin
        o_req = '0;
        o_done = 1'b0;
    end
    // Hold a request until granted, then drop it so it does not ask twice
    always @(posedge i_clk) begin
        #1;
        o_req = (o_req | (i_rnd[7:4] & i_rnd[11:8])) & ~i_grant;
        // Owner ends promptly or after a random slow span
        o_done = (i_grant != '0) && (i_rnd[14] || i_rnd[13:12] == 2'h0);
    end
endmodule

// *** verification/data_memory_bus_priority_arbiter_tb.sv ***
// Self-checking bench of the data memory bus priority arbiter
module data_memory_bus_priority_arbiter_tb
    import dmba_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ========
    // Signals and reference state
    logic i_clk, i_rst_b, i_ce, i_done, o_busy;
    logic [15:0] ctrl, rnd;
    dmba_vec_t i_req, o_grant, o_pending;
    logic [31:0] lfsr = 32'h18f6;
    logic [3:0] m_pend = '0, m_gnt = '0;
    logic [15:0] m_ctrl = '0;
    int sync = 0, error_cnt = 0, checks = 0;
    logic [15:0] modes [4] = '{16'h0000, 16'h0008, 16'h0020, 16'h0028};
    dmba_arbiter i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
        .i_bus_master_priority_control(ctrl), .i_req(i_req),
        .i_done(i_done), .o_grant(o_grant), .o_pending(o_pending),
        .o_busy(o_busy));
    dmba_masters i_masters (.i_clk(i_clk), .i_rnd(rnd),
        .i_grant(o_grant), .o_req(i_req), .o_done(i_done));
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Winner index: order packed two bits a slot, highest slot first
    function automatic int pick(input logic [15:0] c, input logic [3:0] r);
        logic [7:0] o;
        o = c[5] ? (c[3] ? 8'hc6 : 8'he1) : (c[3] ? 8'hd2 : 8'hd8);
        for (int k = 0; k < 4; k++) if (r[o[2*k+:2]]) return int'(o[2*k+:2]);
        return -1;
    endfunction
    task automatic check(input string nm, input logic [3:0] e, input logic [3:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Model steps only after the two-flop reset release has cleared
    always @(posedge i_clk or negedge i_rst_b) begin
        int w;
        if (!i_rst_b) begin
            sync = 0;
            m_pend = '0;
            m_gnt = '0;
            m_ctrl = '0;
        end else begin
            if (sync < 3) sync++;
            if (sync == 3 && i_ce) begin
                m_pend = m_pend | i_req;
                if (m_gnt == '0 || i_done) begin
                    w = pick(m_ctrl, m_pend);
                    m_gnt = (w < 0) ? 4'h0 : 4'h1 << w;
                    m_pend = m_pend & ~m_gnt;
                end
                m_ctrl = ctrl;
            end
        end
    end
    // Outputs are registered, so compare away from the rising edge
    always @(negedge i_clk) begin
        check("grant", m_gnt, o_grant);
        check("pending", m_pend, o_pending);
        check("busy", {3'h0, m_gnt != '0}, {3'h0, o_busy});
    end
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Watchdog well beyond the 1600 cycles of the sequence
    initial begin
        #50000;
        error_cnt++;
        give_verdict();
    end
    // Every legal ordering twice, random traffic, a reset mid-run
    initial begin
        i_rst_b = 1'b0;
        i_ce = 1'b1;
        ctrl = 16'h0000;
        rnd = '0;
        repeat (2) @(posedge i_clk);
        #1 i_rst_b = 1'b1;
        for (int p = 0; p < 8; p++) begin
            for (int n = 0; n < 200; n++) begin
                @(posedge i_clk);
                #1;
                i_rst_b = !(p == 4 && n < 2);
                ctrl = modes[p % 4];
                lfsr = lfsr_next(lfsr);
                rnd = lfsr[15:0];
                // Clock enable stays high while the reset release settles
                i_ce = (n < 8) || (lfsr[20:18] != 3'h0);
            end
        end
        give_verdict();
    end
endmodule
